//--- logic/pin_mux_pkg.sv
// Constants shared by the shared-pin function select block and its strap capture.
// Assumes a single 25 MHz core clock and a synchronous active-low reset.
package pin_mux_pkg;

	// ************************************************************
	// Clocking and derived timing counts.
	// ************************************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int MDC_FREQ_HZ = 2_500_000;
	// Longest half period of the management clock, rounded down, never below one cycle.
	localparam int MDC_HALF_CYC = (CLK_HZ / (2 * MDC_FREQ_HZ)) < 1 ? 1 : (CLK_HZ / (2 * MDC_FREQ_HZ));
	localparam int MDC_CNT_W = 3;
	localparam int SPI_SCK_MAX_HZ = 25_000_000;

	// ************************************************************
	// Field positions and widths.
	// ************************************************************
	localparam int NUM_SHARED = 5;
	localparam int NUM_PORTS = 6;
	localparam int IRQ_EN_LINK_BIT = 0;
	localparam int IRQ_EN_QUEUE_BIT = 1;
	// Synchronised pin inputs: management clock, management data, serial clock, select.
	localparam int SYNC_MDC = 0;
	localparam int SYNC_MDIO = 1;
	localparam int SYNC_SCK = 2;
	localparam int SYNC_SEL = 3;
	localparam int NUM_SYNC = 4;
	// Strap inputs into the capture module.
	localparam int STRAP_WAN = 0;
	localparam int STRAP_LAMP1 = 1;
	localparam int STRAP_HOST = 2;
	localparam int STRAP_MGMT = 3;
	localparam int NUM_STRAP = 4;

	// ************************************************************
	// Reset values.
	// ************************************************************
	localparam logic [NUM_SHARED-1:0] SHARED_PIN_RST = 5'h00;
	localparam logic [NUM_PORTS-1:0] LINK_SEEN_RST = 6'h00;
	localparam logic IRQ_N_RST = 1'h1;
	localparam logic [MDC_CNT_W-1:0] MDC_CNT_RST = 3'h0;
	// Synchronised levels start at each pin's pulled idle level: select pulled up, the rest pulled down.
	localparam logic [NUM_SYNC-1:0] SYNC_LEVEL_RST = 4'h8;

endpackage

//--- logic/shared_pin_function_select.sv
// Shared pin function select: WAN transmit or lamp pins, interrupt pin, management and serial pin roles.
// Assumes one 25 MHz core clock, synchronous active-low reset, and core logic on the same clock.
`timescale 1ns/1ps

module shared_pin_function_select
	import pin_mux_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Strap pins sampled during reset.
	input wire logic uart_tx_with_wan_strap_i,
	input wire logic serial_host_strap_i,
	input wire logic mgmt_master_strap_i,
	// Latched strap selections.
	output logic wan_or_lamp_pin_select_o,
	output logic lamp_style_strap_bit1_o,
	output logic mgmt_master_o,
	output logic spi_slave_mode_o,
	// Core WAN transmit and lamp requests.
	input wire logic [3:0] wan_txd_i,
	input wire logic wan_txen_i,
	input wire logic [NUM_SHARED-1:0] lamp_on_i,
	// Shared WAN transmit and lamp pins.
	output logic shared_lamp10_wan_txd0_o,
	output logic shared_lamp11_wan_txd1_o,
	output logic shared_lamp12_wan_txd2_o,
	output logic shared_lamp13_wan_txd3_o,
	output logic shared_lamp14_wan_txen_o,
	// Interrupt sources and control.
	input wire logic [NUM_PORTS-1:0] link_change_i,
	input wire logic [NUM_PORTS-1:0] link_change_clr_i,
	input wire logic cpu_port_queue_busy_i,
	input wire logic [1:0] irq_enable_i,
	output logic [NUM_PORTS-1:0] link_change_seen_o,
	// Interrupt pin with lamp strap.
	input wire logic irq_out_n_with_lamp_strap_i,
	output logic irq_out_n_with_lamp_strap_o,
	output logic irq_out_n_with_lamp_strap_oe_o,
	// Management clock and data pins.
	input wire logic mdc_pin_i,
	output logic mdc_pin_o,
	output logic mdc_pin_oe_o,
	input wire logic mdio_pin_i,
	output logic mdio_pin_o,
	output logic mdio_pin_oe_o,
	// Management core side.
	input wire logic mdio_drive_i,
	input wire logic mdio_drive_en_i,
	output logic mdio_in_o,
	output logic mdc_rise_o,
	// Serial clock, select and slave-out pins.
	input wire logic shared_serial_clock_pin_i,
	output logic shared_serial_clock_pin_o,
	output logic shared_serial_clock_pin_oe_o,
	input wire logic shared_select_pin_i,
	output logic shared_select_pin_o,
	output logic shared_select_pin_oe_o,
	output logic shared_serial_out_pin_o,
	output logic shared_serial_out_pin_oe_o,
	// Serial core side.
	input wire logic ee_clk_i,
	input wire logic ee_cs_i,
	input wire logic ee_dout_i,
	input wire logic spi_read_i,
	input wire logic spi_miso_bit_i,
	output logic spi_selected_o,
	output logic sck_rise_o,
	output logic sck_fall_o
);

	// ************************************************************
	// Strap capture.
	// ************************************************************
	strap_bus_if straps ();

	// The interrupt pin is an input while reset holds it undriven, so its level is the strap.
	strap_capture u_strap_capture (
		.clk_i (clk_i),
		.rstn_i (rstn_i),
		.strap_pin_i ({mgmt_master_strap_i, serial_host_strap_i, irq_out_n_with_lamp_strap_i,
			uart_tx_with_wan_strap_i}),
		.straps (straps.capture)
	);

	assign wan_or_lamp_pin_select_o = straps.wan_or_lamp_pin_select;
	assign lamp_style_strap_bit1_o = straps.lamp_style_strap_bit1;
	assign mgmt_master_o = straps.mgmt_master;
	assign spi_slave_mode_o = straps.spi_slave;

	// ************************************************************
	// Shared WAN transmit and lamp pins.
	// ************************************************************
	logic [NUM_SHARED-1:0] shared_pin_r;

	// Lamps are inverted here, so the lamp style strap has no say over these five pins.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			shared_pin_r <= SHARED_PIN_RST;
		end
		else if (straps.wan_or_lamp_pin_select)
		begin
			shared_pin_r <= ~lamp_on_i;
		end
		else
		begin
			shared_pin_r <= {wan_txen_i, wan_txd_i};
		end
	end

	assign shared_lamp10_wan_txd0_o = shared_pin_r[0];
	assign shared_lamp11_wan_txd1_o = shared_pin_r[1];
	assign shared_lamp12_wan_txd2_o = shared_pin_r[2];
	assign shared_lamp13_wan_txd3_o = shared_pin_r[3];
	assign shared_lamp14_wan_txen_o = shared_pin_r[4];

	// ************************************************************
	// Interrupt.
	// ************************************************************
	logic [NUM_PORTS-1:0] link_seen_r;
	logic irq_n_r;
	logic irq_oe_r;
	logic irq_active;

	// Sticky link-change flags; a change in the clearing cycle survives.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			link_seen_r <= LINK_SEEN_RST;
		end
		else
		begin
			link_seen_r <= (link_seen_r & ~link_change_clr_i) | link_change_i;
		end
	end

	assign link_change_seen_o = link_seen_r;

	// Only enabled sources reach the pin.
	assign irq_active = (irq_enable_i[IRQ_EN_LINK_BIT] && (|link_seen_r))
		|| (irq_enable_i[IRQ_EN_QUEUE_BIT] && cpu_port_queue_busy_i);

	// The pin stays undriven through reset so the strap level can be read.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			irq_n_r <= IRQ_N_RST;
			irq_oe_r <= 1'h0;
		end
		else
		begin
			irq_n_r <= ~irq_active;
			irq_oe_r <= 1'h1;
		end
	end

	assign irq_out_n_with_lamp_strap_o = irq_n_r;
	assign irq_out_n_with_lamp_strap_oe_o = irq_oe_r;

	// ************************************************************
	// Pin input synchronisers.
	// ************************************************************
	logic [NUM_SYNC-1:0] pin_raw;
	logic [NUM_SYNC-1:0] sync1_r;
	logic [NUM_SYNC-1:0] sync2_r;
	logic [NUM_SYNC-1:0] sync3_r;
	logic [NUM_SYNC-1:0] level_r;
	logic [NUM_SYNC-1:0] level_prev_r;

	assign pin_raw = {shared_select_pin_i, shared_serial_clock_pin_i, mdio_pin_i, mdc_pin_i};

	// A level is accepted only once stages two and three agree.
	// Levels reset to the pin's idle level, so no false clock edge is reported after reset.
	genvar g;
	generate
		for (g = 0; g < NUM_SYNC; g++)
		begin : g_sync
			always_ff @(posedge clk_i)
			begin
				sync1_r[g] <= pin_raw[g];
				sync2_r[g] <= sync1_r[g];
				sync3_r[g] <= sync2_r[g];
			end

			always_ff @(posedge clk_i)
			begin
				if (!rstn_i)
				begin
					level_r[g] <= SYNC_LEVEL_RST[g];
					level_prev_r[g] <= SYNC_LEVEL_RST[g];
				end
				else
				begin
					if (sync2_r[g] == sync3_r[g])
					begin
						level_r[g] <= sync3_r[g];
					end
					level_prev_r[g] <= level_r[g];
				end
			end
		end
	endgenerate

	// ************************************************************
	// Management clock and data.
	// ************************************************************
	logic [MDC_CNT_W-1:0] mdc_cnt_r;
	logic mdc_clk_r;
	logic mdio_o_r;
	logic mdio_oe_r;
	logic mdc_oe_r;

	// Divide the core clock down to the management clock.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			mdc_cnt_r <= MDC_CNT_RST;
			mdc_clk_r <= 1'h0;
		end
		else if (mdc_cnt_r == MDC_CNT_W'(MDC_HALF_CYC - 1))
		begin
			mdc_cnt_r <= MDC_CNT_RST;
			mdc_clk_r <= ~mdc_clk_r;
		end
		else
		begin
			mdc_cnt_r <= mdc_cnt_r + 3'h1;
		end
	end

	// In slave mode the clock pin is released and the outside party owns the clock.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			mdc_oe_r <= 1'h0;
			mdio_o_r <= 1'h0;
			mdio_oe_r <= 1'h0;
		end
		else
		begin
			mdc_oe_r <= straps.mgmt_master;
			mdio_o_r <= mdio_drive_i;
			mdio_oe_r <= mdio_drive_en_i;
		end
	end

	assign mdc_pin_o = mdc_clk_r;
	assign mdc_pin_oe_o = mdc_oe_r;
	assign mdio_pin_o = mdio_o_r;
	assign mdio_pin_oe_o = mdio_oe_r;
	assign mdio_in_o = level_r[SYNC_MDIO];
	// Slave-mode frames to the virtual endpoint are clocked from the outside clock's edges.
	assign mdc_rise_o = straps.mgmt_master ? (mdc_clk_r && (mdc_cnt_r == MDC_CNT_RST))
		: (level_r[SYNC_MDC] && !level_prev_r[SYNC_MDC]);

	// ************************************************************
	// Serial host or memory pins.
	// ************************************************************
	logic sck_o_r;
	logic sck_oe_r;
	logic sel_o_r;
	logic sel_oe_r;
	logic sout_r;
	logic sout_oe_r;

	// Sampling a slave clock on the 25 MHz core clock only follows clocks well below the top rate.
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			sck_o_r <= 1'h0;
			sck_oe_r <= 1'h0;
			sel_o_r <= 1'h0;
			sel_oe_r <= 1'h0;
			sout_r <= 1'h0;
			sout_oe_r <= 1'h0;
		end
		else if (straps.spi_slave)
		begin
			sck_o_r <= 1'h0;
			sck_oe_r <= 1'h0;
			sel_o_r <= 1'h0;
			sel_oe_r <= 1'h0;
			sout_r <= spi_miso_bit_i;
			sout_oe_r <= !level_r[SYNC_SEL] && spi_read_i;
		end
		else
		begin
			sck_o_r <= ee_clk_i;
			sck_oe_r <= 1'h1;
			sel_o_r <= ee_cs_i;
			sel_oe_r <= 1'h1;
			sout_r <= ee_dout_i;
			sout_oe_r <= 1'h1;
		end
	end

	assign shared_serial_clock_pin_o = sck_o_r;
	assign shared_serial_clock_pin_oe_o = sck_oe_r;
	assign shared_select_pin_o = sel_o_r;
	assign shared_select_pin_oe_o = sel_oe_r;
	assign shared_serial_out_pin_o = sout_r;
	assign shared_serial_out_pin_oe_o = sout_oe_r;
	assign spi_selected_o = straps.spi_slave && !level_r[SYNC_SEL];
	assign sck_rise_o = straps.spi_slave && level_r[SYNC_SCK] && !level_prev_r[SYNC_SCK];
	assign sck_fall_o = straps.spi_slave && !level_r[SYNC_SCK] && level_prev_r[SYNC_SCK];

	// ************************************************************
	// Assertions.
	// ************************************************************
	AST_WAN_DATA: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && !straps.wan_or_lamp_pin_select) |-> (shared_pin_r[3:0] == $past(wan_txd_i)))
		else $error("WAN data pins do not follow transmit data.");

	AST_WAN_TXEN: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && !straps.wan_or_lamp_pin_select) |-> (shared_lamp14_wan_txen_o == $past(wan_txen_i)))
		else $error("WAN enable pin does not follow transmit enable.");

	AST_LAMP_LOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && straps.wan_or_lamp_pin_select) |-> (shared_pin_r == ~$past(lamp_on_i)))
		else $error("Lamp pins are not active low.");

	AST_IRQ_MASKED: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && ($past(irq_enable_i) == 2'h0)) |-> irq_out_n_with_lamp_strap_o)
		else $error("Interrupt asserted with all sources disabled.");

	AST_IRQ_LINK: assert property (@(posedge clk_i) disable iff (!rstn_i)
		((|link_change_i) && irq_enable_i[IRQ_EN_LINK_BIT]) ##1
		(irq_enable_i[IRQ_EN_LINK_BIT] && (link_change_clr_i == 6'h00)) |=> !irq_out_n_with_lamp_strap_o)
		else $error("Link change did not raise the interrupt within two cycles.");

	AST_IRQ_STRAP_WINDOW: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(rstn_i) |-> (!irq_out_n_with_lamp_strap_oe_o ##1 irq_out_n_with_lamp_strap_oe_o))
		else $error("Interrupt pin driven before the strap was taken.");

	AST_MDC_HALF: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(mdc_clk_r) |-> (mdc_clk_r [*5] ##1 !mdc_clk_r))
		else $error("Management clock half period is not five cycles.");

	AST_SCK_DIR: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> (shared_serial_clock_pin_oe_o == !straps.spi_slave))
		else $error("Serial clock pin direction does not match host strap.");

	AST_EE_SELECT: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && !straps.spi_slave) |-> (shared_select_pin_oe_o && (shared_select_pin_o == $past(ee_cs_i))))
		else $error("Memory chip select not driven from the core request.");

	AST_MISO_DRIVE: assert property (@(posedge clk_i) disable iff (!rstn_i)
		($past(rstn_i) && straps.spi_slave && $past(spi_read_i) && !$past(level_r[SYNC_SEL]))
		|-> (shared_serial_out_pin_oe_o && (shared_serial_out_pin_o == $past(spi_miso_bit_i))))
		else $error("Slave-out pin not driven during a selected read.");

endmodule // shared_pin_function_select

//--- logic/strap_bus_if.sv
// Carries the latched strap selections from the capture module to the pin logic.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps

interface strap_bus_if;
	logic wan_or_lamp_pin_select;
	logic lamp_style_strap_bit1;
	logic mgmt_master;
	logic spi_slave;

	modport capture (output wan_or_lamp_pin_select, output lamp_style_strap_bit1, output mgmt_master, output spi_slave);
	modport user (input wan_or_lamp_pin_select, input lamp_style_strap_bit1, input mgmt_master, input spi_slave);
endinterface // strap_bus_if

//--- logic/strap_capture.sv
// Strap capture: synchronises the strap pins and latches them while reset is low.
// Assumes the strap pins are asynchronous and that reset is held for at least four clocks.
`timescale 1ns/1ps

module strap_capture
	import pin_mux_pkg::*;
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Raw strap pin levels.
	input wire logic [NUM_STRAP-1:0] strap_pin_i,
	// Latched selections.
	strap_bus_if.capture straps
);

	// ************************************************************
	// Synchroniser and latch.
	// ************************************************************
	logic [NUM_STRAP-1:0] sync1_r;
	logic [NUM_STRAP-1:0] sync2_r;
	logic [NUM_STRAP-1:0] sync3_r;
	logic [NUM_STRAP-1:0] latch_r;

	// Three-stage synchroniser; it runs through reset so the straps settle before release.
	always_ff @(posedge clk_i)
	begin
		sync1_r <= strap_pin_i;
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	// Each strap follows the pin during reset, once stages two and three agree, then freezes.
	genvar g;
	generate
		for (g = 0; g < NUM_STRAP; g++)
		begin : g_latch
			always_ff @(posedge clk_i)
			begin
				if (!rstn_i && (sync2_r[g] == sync3_r[g]))
				begin
					latch_r[g] <= sync3_r[g];
				end
			end
		end
	endgenerate

	assign straps.wan_or_lamp_pin_select = latch_r[STRAP_WAN];
	assign straps.lamp_style_strap_bit1 = latch_r[STRAP_LAMP1];
	assign straps.mgmt_master = latch_r[STRAP_MGMT];
	assign straps.spi_slave = latch_r[STRAP_HOST];

	// Straps never move once reset has been released.
	AST_STRAP_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$past(rstn_i) |-> $stable(latch_r))
		else $error("Strap selection changed outside reset.");

endmodule // strap_capture

//--- sim/far_side_model.sv
// Far-side model: serial master, management clock source and pin pulls for the shared pins.
// Assumes the device drives each pin only while its enable is high and that the bench calls the tasks.
`timescale 1ns/1ps

module far_side_model
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rstn_i,
	// Device drivers and their enables.
	input wire logic irq_dev_i,
	input wire logic irq_oe_i,
	input wire logic mdc_dev_i,
	input wire logic mdc_oe_i,
	input wire logic sck_dev_i,
	input wire logic sck_oe_i,
	input wire logic sel_dev_i,
	input wire logic sel_oe_i,
	input wire logic mdio_dev_i,
	input wire logic mdio_oe_i,
	// Resolved wire levels.
	output logic irq_line_o,
	output logic mdc_line_o,
	output logic sck_line_o,
	output logic sel_line_o,
	output logic mdio_line_o
);
	logic lamp1_v = 1'b1;
	logic mdc_v = 1'b0;
	logic sck_v = 1'b0;
	logic sel_n = 1'b1;

	// Released lines fall to their pulls; clocks stand still between bursts.
	assign irq_line_o = irq_oe_i ? irq_dev_i : ((!rstn_i && !lamp1_v) ? 1'b0 : 1'b1);
	assign mdc_line_o = mdc_oe_i ? mdc_dev_i : mdc_v;
	assign sck_line_o = sck_oe_i ? sck_dev_i : sck_v;
	assign sel_line_o = sel_oe_i ? sel_dev_i : sel_n;
	assign mdio_line_o = mdio_oe_i ? mdio_dev_i : 1'b0;

	// Slow clock burst, half period of eight core cycles, far below the serial limit.
	task burst(input logic mgmt, input int n);
		repeat (n)
		begin
			repeat (8) @(posedge clk_i);
			if (mgmt) mdc_v <= 1'b1;
			else sck_v <= 1'b1;
			repeat (8) @(posedge clk_i);
			if (mgmt) mdc_v <= 1'b0;
			else sck_v <= 1'b0;
		end
	endtask

	// The master pulls the select low around each transaction.
	task select(input logic on);
		@(posedge clk_i);
		sel_n <= !on;
	endtask
endmodule // far_side_model

//--- sim/tb_shared_pin_function_select.sv
// Self-checking bench for the shared pin function select block.
// Assumes the far-side model resolves the two-way pins and the design asserts internally.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module tb_shared_pin_function_select
	import pin_mux_pkg::*;
;
	logic clk_i, rstn_i, uart_tx_with_wan_strap_i, serial_host_strap_i, mgmt_master_strap_i;
	logic [3:0] wan_txd_i;
	logic wan_txen_i, cpu_port_queue_busy_i, mdio_drive_i, mdio_drive_en_i;
	logic ee_clk_i, ee_cs_i, ee_dout_i, spi_read_i, spi_miso_bit_i;
	logic [NUM_SHARED-1:0] lamp_on_i, pins;
	logic [NUM_PORTS-1:0] link_change_i, link_change_clr_i, link_change_seen_o;
	logic [1:0] irq_enable_i;
	logic wan_or_lamp_pin_select_o, lamp_style_strap_bit1_o, mgmt_master_o, spi_slave_mode_o;
	logic irq_i, irq_o, irq_oe, mdc_i, mdc_o, mdc_oe, mdio_i, mdio_o, mdio_oe, mdio_in_o, mdc_rise_o;
	logic sck_i, sck_o, sck_oe, sel_i, sel_o, sel_oe, out_o, out_oe, spi_selected_o, sck_rise_o, sck_fall_o;
	int seed = 21732;
	int error_cnt = 0;
	int n_tests = 0;
	int rise_cnt, fall_cnt, mrise_cnt, mhigh_cnt;

	shared_pin_function_select dut (.clk_i, .rstn_i, .uart_tx_with_wan_strap_i, .serial_host_strap_i,
		.mgmt_master_strap_i, .wan_or_lamp_pin_select_o, .lamp_style_strap_bit1_o, .mgmt_master_o,
		.spi_slave_mode_o, .wan_txd_i, .wan_txen_i, .lamp_on_i, .shared_lamp10_wan_txd0_o(pins[0]),
		.shared_lamp11_wan_txd1_o(pins[1]), .shared_lamp12_wan_txd2_o(pins[2]), .shared_lamp13_wan_txd3_o(pins[3]),
		.shared_lamp14_wan_txen_o(pins[4]), .link_change_i, .link_change_clr_i, .cpu_port_queue_busy_i,
		.irq_enable_i, .link_change_seen_o, .irq_out_n_with_lamp_strap_i(irq_i), .irq_out_n_with_lamp_strap_o(irq_o),
		.irq_out_n_with_lamp_strap_oe_o(irq_oe), .mdc_pin_i(mdc_i), .mdc_pin_o(mdc_o), .mdc_pin_oe_o(mdc_oe),
		.mdio_pin_i(mdio_i), .mdio_pin_o(mdio_o), .mdio_pin_oe_o(mdio_oe), .mdio_drive_i, .mdio_drive_en_i,
		.mdio_in_o, .mdc_rise_o, .shared_serial_clock_pin_i(sck_i), .shared_serial_clock_pin_o(sck_o),
		.shared_serial_clock_pin_oe_o(sck_oe), .shared_select_pin_i(sel_i), .shared_select_pin_o(sel_o),
		.shared_select_pin_oe_o(sel_oe), .shared_serial_out_pin_o(out_o), .shared_serial_out_pin_oe_o(out_oe),
		.ee_clk_i, .ee_cs_i, .ee_dout_i, .spi_read_i, .spi_miso_bit_i, .spi_selected_o, .sck_rise_o, .sck_fall_o);

	far_side_model fs (.clk_i(clk_i), .rstn_i(rstn_i), .irq_dev_i(irq_o), .irq_oe_i(irq_oe), .mdc_dev_i(mdc_o),
		.mdc_oe_i(mdc_oe), .sck_dev_i(sck_o), .sck_oe_i(sck_oe), .sel_dev_i(sel_o), .sel_oe_i(sel_oe),
		.mdio_dev_i(mdio_o), .mdio_oe_i(mdio_oe), .irq_line_o(irq_i), .mdc_line_o(mdc_i), .sck_line_o(sck_i),
		.sel_line_o(sel_i), .mdio_line_o(mdio_i));

	// ************************************************************
	// Clock, edge counters and watchdog.
	// ************************************************************
	// The core clock runs at 25 MHz.
	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Pulses are counted on every rising clock edge so that a doubled or lost pulse shows.
	always @(posedge clk_i)
	begin
		if (sck_rise_o === 1'b1) rise_cnt++;
		if (sck_fall_o === 1'b1) fall_cnt++;
		if (mdc_rise_o === 1'b1) mrise_cnt++;
		if (mdc_o === 1'b1) mhigh_cnt++;
	end

	// The whole run needs about 375 cycles, so more than twenty-five times that means a hang.
	initial
	begin
		repeat (10000) @(posedge clk_i);
		error_cnt++;
		finish_test();
	end

	// ************************************************************
	// Expectations and helpers.
	// ************************************************************
	// Shared pin levels: lamps are active low in lamp mode, WAN transmit bits otherwise.
	function automatic logic [4:0] pin_exp(input logic lamps, input logic [3:0] d, input logic en,
		input logic [4:0] lamp);
		return lamps ? ~lamp : {en, d};
	endfunction

	task finish_test();
		$display("Counts: %0d checks, %0d mismatches", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task do_reset(input logic w, input logic h, input logic m, input logic l);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		uart_tx_with_wan_strap_i <= w;
		serial_host_strap_i <= h;
		mgmt_master_strap_i <= m;
		fs.lamp1_v <= l;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		#1;
		`CHK({wan_or_lamp_pin_select_o, lamp_style_strap_bit1_o, mgmt_master_o, spi_slave_mode_o}, {w, l, m, h})
		`CHK({irq_oe, irq_o}, 2'h3)
		@(posedge clk_i);
		uart_tx_with_wan_strap_i <= !w;
		serial_host_strap_i <= !h;
		mgmt_master_strap_i <= !m;
	endtask

	// Random traffic on the WAN, lamp, management and memory core inputs, compared one cycle later, back to back; memory inputs only in master mode.
	task rand_run(input logic lamps);
		logic [31:0] r;
		logic [4:0] ep;
		logic [2:0] es;
		logic [1:0] em;
		ep = pin_exp(lamps, wan_txd_i, wan_txen_i, lamp_on_i);
		es = {ee_clk_i, ee_cs_i, ee_dout_i};
		em = {mdio_drive_en_i, mdio_drive_i};
		repeat (40)
		begin
			@(posedge clk_i);
			r = $random(seed);
			{ee_dout_i, ee_cs_i, ee_clk_i, mdio_drive_en_i, mdio_drive_i, lamp_on_i, wan_txen_i, wan_txd_i} <= r[14:0];
			#1;
			`CHK(pins, ep)
			`CHK({mdio_oe, mdio_o}, em)
			if (lamps) `CHK({sck_o, sel_o, out_o, sck_oe, sel_oe, out_oe}, {es, 3'h7})
			else `CHK({sck_oe, sel_oe}, 2'h0)
			ep = pin_exp(lamps, wan_txd_i, wan_txen_i, lamp_on_i);
			es = {ee_clk_i, ee_cs_i, ee_dout_i};
			em = {mdio_drive_en_i, mdio_drive_i};
		end
		`CHK({wan_or_lamp_pin_select_o, spi_slave_mode_o}, {lamps, !lamps})
	endtask

	// ************************************************************
	// Main sequence.
	// ************************************************************
	initial
	begin
		rstn_i = 1'b0;
		{uart_tx_with_wan_strap_i, serial_host_strap_i, mgmt_master_strap_i} = 3'h2;
		{wan_txd_i, wan_txen_i, lamp_on_i, cpu_port_queue_busy_i} = 11'h000;
		{mdio_drive_i, mdio_drive_en_i, ee_clk_i, ee_cs_i, ee_dout_i, spi_read_i, spi_miso_bit_i} = 7'h00;
		{link_change_i, link_change_clr_i, irq_enable_i} = 14'h0000;
		// WAN mode, serial slave, management slave, lamp strap high.
		do_reset(1'b0, 1'b1, 1'b0, 1'b1);
		rand_run(1'b0);
		$display("Test wan_slave done");
		// Every port pulls the pin low through the link source, then clears it.
		@(posedge clk_i);
		irq_enable_i <= 2'h1;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			@(posedge clk_i);
			link_change_i <= 6'h01 << p;
			@(posedge clk_i);
			link_change_i <= 6'h00;
			repeat (2) @(posedge clk_i);
			#1;
			`CHK(link_change_seen_o, 6'h01 << p)
			`CHK(irq_o, 1'b0)
			@(posedge clk_i);
			link_change_clr_i <= 6'h01 << p;
			@(posedge clk_i);
			link_change_clr_i <= 6'h00;
			repeat (2) @(posedge clk_i);
			#1;
			`CHK({link_change_seen_o, irq_o}, 7'h01)
		end
		// A disabled link source only sets its flag, even against a clear in the same cycle.
		// The queue source then drives the pin.
		@(posedge clk_i);
		irq_enable_i <= 2'h2;
		link_change_i <= 6'h20;
		link_change_clr_i <= 6'h20;
		@(posedge clk_i);
		link_change_i <= 6'h00;
		link_change_clr_i <= 6'h00;
		repeat (2) @(posedge clk_i);
		#1;
		`CHK({link_change_seen_o, irq_o}, 7'h41)
		@(posedge clk_i);
		cpu_port_queue_busy_i <= 1'b1;
		link_change_clr_i <= 6'h3f;
		repeat (3) @(posedge clk_i);
		#1;
		`CHK(irq_o, 1'b0)
		@(posedge clk_i);
		cpu_port_queue_busy_i <= 1'b0;
		link_change_clr_i <= 6'h00;
		repeat (3) @(posedge clk_i);
		#1;
		`CHK(irq_o, 1'b1)
		$display("Test interrupt done");
		// Serial slave: select, clock burst and read data out.
		fs.select(1'b1);
		spi_read_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		`CHK(spi_selected_o, 1'b1)
		repeat (10)
		begin
			@(posedge clk_i);
			spi_miso_bit_i <= 1'($random(seed));
			#1;
		end
		@(posedge clk_i);
		#1;
		`CHK({out_oe, out_o}, {1'b1, spi_miso_bit_i})
		rise_cnt = 0;
		fall_cnt = 0;
		mrise_cnt = 0;
		fs.burst(1'b0, 4);
		fs.burst(1'b1, 3);
		repeat (8) @(posedge clk_i);
		#1;
		`CHK({rise_cnt[3:0], fall_cnt[3:0]}, 8'h44)
		`CHK({mrise_cnt[3:0], mdc_oe}, 5'h6)
		fs.select(1'b0);
		repeat (8) @(posedge clk_i);
		#1;
		`CHK({spi_selected_o, out_oe}, 2'h0)
		$display("Test serial_slave done");
		// Lamp mode, memory master, management master, lamp strap low.
		do_reset(1'b1, 1'b0, 1'b1, 1'b0);
		mrise_cnt = 0;
		mhigh_cnt = 0;
		rand_run(1'b1);
		repeat (59) @(posedge clk_i);
		#1;
		`CHK({mrise_cnt[7:0], mhigh_cnt[7:0], mdc_oe}, {8'h0a, 8'h32, 1'b1})
		`CHK(mdio_in_o, mdio_drive_en_i & mdio_drive_i)
		$display("Test lamp_master done");
		finish_test();
	end
endmodule // tb_shared_pin_function_select
